// File: verilog/prmw_pkg.sv
// Shared constants and carrier types for the read-multiple target path and master windows
package prmw_pkg;
   // ----------------------------------------------------------------
   // Bus commands
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_MEM_READ = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] CMD_READ_MULTI = 4'hc;
   localparam logic [3:0] CMD_READ_LINE = 4'he;
   localparam logic [3:0] CMD_WRITE_INV = 4'hf;
   // ----------------------------------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------------------------------
   localparam int REG_AW = 9;
   localparam logic [8:0] OFF_WIN_SUB = 9'h000;
   localparam logic [8:0] OFF_TGT_CTL = 9'h080;
   localparam logic [8:0] OFF_BAR = 9'h100;
   localparam logic [8:0] OFF_BAR_MSK = 9'h120;
   localparam logic [8:0] OFF_STATUS = 9'h140;
   localparam int CTL_FORCE_BIT = 0;
   localparam int CTL_BURST_BIT = 1;
   localparam int CTL_CLS_LSB = 8;
   localparam int CLS_W = 5;
   localparam int STS_DLY_BIT = 0;
   localparam int STS_ACT_BIT = 1;
   localparam int STS_CNT_LSB = 8;
   // ----------------------------------------------------------------
   // Windows and base registers
   // ----------------------------------------------------------------
   localparam int NUM_WIN = 32;
   localparam int WIN_IDX_LSB = 23;
   localparam int WIN_IDX_W = 5;
   localparam int SUB_W = 9;
   localparam logic [22:0] SUB_RSVD_ZERO = 23'h000000;
   localparam int NUM_BAR = 6;
   localparam int BAR_IO_BIT = 0;
   localparam logic [31:0] BAR_LOW_IGNORE = 32'h0000000f;
   // ----------------------------------------------------------------
   // Prefetch sizing
   // ----------------------------------------------------------------
   localparam int BUF_AW = 4;
   localparam logic [4:0] BUF_WORDS = 5'h10;
   localparam logic [4:0] FIRST_FETCH_WORDS = 5'h10;
   localparam logic [4:0] REFILL_WORDS = 5'h08;
   localparam logic [3:0] BE_ALL = 4'hf;
   localparam logic [3:0] WAIT_PCLKS_DEF = 4'hc;

   typedef enum logic [2:0] {T_IDLE, T_WAIT, T_RETRY, T_BURST, T_END} prmw_tstate_t;

   typedef struct packed {
      logic clk;
      logic frame_n;
      logic irdy_n;
      logic [3:0] cbe;
      logic [31:0] ad;
   } prmw_pci_in_t;

   typedef struct packed {
      logic devsel_n;
      logic trdy_n;
      logic stop_n;
      logic ctl_oe;
      logic [31:0] ad;
      logic ad_oe;
   } prmw_tgt_out_t;

   typedef struct packed {
      logic req;
      logic [31:0] addr;
      logic [4:0] len;
      logic [3:0] be;
   } prmw_dsp_rd_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic proxy;
      logic [3:0] proxy_cmd;
      logic [31:0] addr;
      logic [4:0] len;
   } prmw_mst_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] cmd;
      logic [31:0] addr;
   } prmw_mst_out_t;
endpackage

// File: verilog/prmw_bridge.sv
// Read-multiple target path, prefetch buffer and master window translation
`timescale 1ns/100ps
// What this block does
// - Only command code Ch in the address phase is a read multiple.
// - Claim only when some base register has bit 0 clear.
// - Compare address bits above the mask, never below bit 4.
// - Retry when another delayed read, data not ready, or write buffer busy.
// - Start the DSP burst read only after pending write bursts finish.
// - First DSP fetch of a burst asks for 16 words.
// - DSP read requests carry all byte enables.
// - Wait at most 12 bus clocks for data, then retry and mark delayed.
// - Force bit retries and marks delayed at once, no wait.
// - Delayed completion asserts target ready together with device select.
// - Keep target ready while buffer holds data until initiator ends.
// - Refill with 8-word fetches as buffer space frees.
// - Master for DSP memory requests and proxy I/O or config requests.
// - Setting picks basic commands only or length-based burst commands.
// - Read buffer of sixteen 32-bit words; write buffer state comes in on inputs.
// - 256MB DSP region split into 32 windows of 8MB.
// - Window n sits at the n-th consecutive 8MB of the region.
// - 32 DSP-writable substitution registers, one per window.
// - Substitution bits 31 to 23 give upper bus address bits.
// - Low 23 substitution bits read as zero.
// - Bus address is substitution field plus low 23 DSP bits.
module prmw_bridge #(
   parameter logic [3:0] WAIT_PCLKS = prmw_pkg::WAIT_PCLKS_DEF
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [prmw_pkg::REG_AW-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic pci_clk_in,
   input wire logic pci_frame_n_in,
   input wire logic pci_irdy_n_in,
   input wire logic [3:0] cmd_byte_enable_lines_in,
   input wire logic [31:0] pci_ad_in,
   output prmw_pkg::prmw_tgt_out_t pci_tgt_out,
   input wire logic wbuf_empty_in,
   input wire logic wr_busy_in,
   output prmw_pkg::prmw_dsp_rd_t dsp_rd_out,
   input wire logic dsp_rd_ack_in,
   input wire logic dsp_rd_valid_in,
   input wire logic [31:0] dsp_rd_data_in,
   input wire prmw_pkg::prmw_mst_req_t mst_req_in,
   output prmw_pkg::prmw_mst_out_t mst_out
);
   import prmw_pkg::*;

   typedef struct packed {
      logic [NUM_WIN-1:0][SUB_W-1:0] sub;
      logic [NUM_BAR-1:0][31:0] bar;
      logic [NUM_BAR-1:0][31:0] msk;
      logic force_dly;
      logic burst_en;
      logic [CLS_W-1:0] cls;
      logic [31:0] rdata;
      prmw_pci_in_t s1;
      prmw_pci_in_t s2;
      logic clk_d;
      prmw_tstate_t tst;
      prmw_tgt_out_t tgt;
      logic [3:0] wait_cnt;
      logic dly_pend;
      logic [31:0] dly_addr;
      logic rd_act;
      logic fetch_pend;
      logic fetch_first;
      logic [31:0] fetch_addr;
      logic [4:0] inflight;
      prmw_dsp_rd_t dsp;
      logic [(1<<BUF_AW)-1:0][31:0] buff;
      logic [BUF_AW-1:0] wptr;
      logic [BUF_AW-1:0] rptr;
      logic [4:0] cnt;
      prmw_mst_out_t mst;
   } prmw_state_t;

   prmw_state_t st;
   prmw_state_t n;
   prmw_pci_in_t pin_now;
   logic pci_rise;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic in_block(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] base,
                                     input int cnt);
      in_block = (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * cnt);
   endfunction

   // Bits below bit 4 never take part, whatever the mask says
   function automatic logic bar_hit(input logic [31:0] ad, input logic [31:0] bar,
                                    input logic [31:0] msk);
      bar_hit = !bar[BAR_IO_BIT] && (((ad ^ bar) & msk & ~BAR_LOW_IGNORE) == 32'h00000000);
   endfunction

   function automatic logic [3:0] pick_cmd(input logic burst_en, input logic wr,
                                           input logic [4:0] len, input logic [CLS_W-1:0] cls);
      if (!burst_en || len <= 5'h01) begin
         pick_cmd = wr ? CMD_MEM_WRITE : CMD_MEM_READ;
      end else if (wr) begin
         pick_cmd = (len >= cls) ? CMD_WRITE_INV : CMD_MEM_WRITE;
      end else begin
         pick_cmd = (len >= cls) ? CMD_READ_MULTI : CMD_READ_LINE;
      end
   endfunction

   assign pin_now.clk = pci_clk_in;
   assign pin_now.frame_n = pci_frame_n_in;
   assign pin_now.irdy_n = pci_irdy_n_in;
   assign pin_now.cbe = cmd_byte_enable_lines_in;
   assign pin_now.ad = pci_ad_in;
   assign pci_rise = st.s2.clk && !st.clk_d;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic hit_any;
      logic push;
      logic pop;
      logic retry;
      logic flush;
      logic [4:0] left;
      hit_any = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      retry = 1'b0;
      flush = 1'b0;
      left = 5'h00;
      n = st;
      // Only the second stage is read by logic
      n.s1 = pin_now;
      n.s2 = st.s1;
      n.clk_d = st.s2.clk;
      for (int i = 0; i < NUM_BAR; i++) begin
         if (bar_hit(st.s2.ad, st.bar[i], st.msk[i])) begin
            hit_any = 1'b1;
         end
      end

      // Register bus
      n.rdata = 32'h00000000;
      if (reg_rd_in) begin
         if (in_block(reg_addr_in, OFF_WIN_SUB, NUM_WIN)) begin
            n.rdata = {st.sub[reg_addr_in[6:2]], SUB_RSVD_ZERO};
         end else if (reg_addr_in == OFF_TGT_CTL) begin
            n.rdata[CTL_FORCE_BIT] = st.force_dly;
            n.rdata[CTL_BURST_BIT] = st.burst_en;
            n.rdata[CTL_CLS_LSB +: CLS_W] = st.cls;
         end else if (in_block(reg_addr_in, OFF_BAR, NUM_BAR)) begin
            n.rdata = st.bar[reg_addr_in[4:2]];
         end else if (in_block(reg_addr_in, OFF_BAR_MSK, NUM_BAR)) begin
            n.rdata = st.msk[reg_addr_in[4:2]];
         end else if (reg_addr_in == OFF_STATUS) begin
            n.rdata[STS_DLY_BIT] = st.dly_pend;
            n.rdata[STS_ACT_BIT] = st.rd_act;
            n.rdata[STS_CNT_LSB +: 5] = st.cnt;
         end
      end
      if (reg_wr_in) begin
         if (in_block(reg_addr_in, OFF_WIN_SUB, NUM_WIN)) begin
            n.sub[reg_addr_in[6:2]] = reg_wdata_in[31:WIN_IDX_LSB];
         end else if (reg_addr_in == OFF_TGT_CTL) begin
            n.force_dly = reg_wdata_in[CTL_FORCE_BIT];
            n.burst_en = reg_wdata_in[CTL_BURST_BIT];
            n.cls = reg_wdata_in[CTL_CLS_LSB +: CLS_W];
         end else if (in_block(reg_addr_in, OFF_BAR, NUM_BAR)) begin
            n.bar[reg_addr_in[4:2]] = reg_wdata_in;
         end else if (in_block(reg_addr_in, OFF_BAR_MSK, NUM_BAR)) begin
            n.msk[reg_addr_in[4:2]] = reg_wdata_in;
         end
      end

      // Target state machine, stepped on each sampled bus clock rise
      if (pci_rise) begin
         case (st.tst)
            T_IDLE: begin
               if (!st.s2.frame_n && st.s2.cbe == CMD_READ_MULTI && hit_any) begin
                  n.tgt.ctl_oe = 1'b1;
                  n.tgt.devsel_n = 1'b0;
                  if (st.dly_pend) begin
                     if (st.s2.ad == st.dly_addr && st.cnt != 5'h00) begin
                        n.tgt.trdy_n = 1'b0;
                        n.tgt.ad = st.buff[st.rptr];
                        n.tgt.ad_oe = 1'b1;
                        n.tst = T_BURST;
                     end else begin
                        retry = 1'b1;
                     end
                  end else if (!wbuf_empty_in || st.inflight != 5'h00 || st.dsp.req) begin
                     // Stale words of an aborted fetch must drain first
                     retry = 1'b1;
                  end else begin
                     n.dly_addr = st.s2.ad;
                     n.fetch_addr = st.s2.ad;
                     n.fetch_pend = 1'b1;
                     n.fetch_first = 1'b1;
                     n.rd_act = 1'b1;
                     n.wait_cnt = 4'h0;
                     if (st.force_dly) begin
                        retry = 1'b1;
                        n.dly_pend = 1'b1;
                     end else begin
                        n.tst = T_WAIT;
                     end
                  end
               end
            end
            T_WAIT: begin
               if (st.cnt != 5'h00) begin
                  n.tgt.trdy_n = 1'b0;
                  n.tgt.ad = st.buff[st.rptr];
                  n.tgt.ad_oe = 1'b1;
                  n.tst = T_BURST;
               end else if (st.wait_cnt == WAIT_PCLKS - 4'h1) begin
                  retry = 1'b1;
                  n.dly_pend = 1'b1;
               end else begin
                  n.wait_cnt = st.wait_cnt + 4'h1;
               end
            end
            T_RETRY: begin
               if (st.s2.frame_n) begin
                  n.tgt.devsel_n = 1'b1;
                  n.tgt.stop_n = 1'b1;
                  n.tst = T_END;
               end
            end
            T_BURST: begin
               pop = !st.s2.irdy_n && !st.tgt.trdy_n;
               left = st.cnt - {4'h0, pop};
               if (st.s2.frame_n && pop) begin
                  n.tgt.devsel_n = 1'b1;
                  n.tgt.trdy_n = 1'b1;
                  n.tgt.ad_oe = 1'b0;
                  n.dly_pend = 1'b0;
                  flush = 1'b1;
                  n.tst = T_END;
               end else if (left != 5'h00) begin
                  n.tgt.trdy_n = 1'b0;
                  n.tgt.ad = st.buff[st.rptr + {3'h0, pop}];
               end else begin
                  n.tgt.trdy_n = 1'b1;
               end
            end
            T_END: begin
               n.tgt.ctl_oe = 1'b0;
               n.tgt.ad_oe = 1'b0;
               n.tst = T_IDLE;
            end
            default: begin
               n.tst = T_IDLE;
            end
         endcase
      end
      if (retry) begin
         n.tgt.devsel_n = 1'b0;
         n.tgt.stop_n = 1'b0;
         n.tgt.trdy_n = 1'b1;
         n.tgt.ctl_oe = 1'b1;
         n.tst = T_RETRY;
      end

      // DSP slave-side fetch engine
      if (st.dsp.req) begin
         if (dsp_rd_ack_in) begin
            n.dsp.req = 1'b0;
            n.inflight = st.inflight + st.dsp.len;
            n.fetch_addr = st.fetch_addr + {25'h0000000, st.dsp.len, 2'b00};
         end
      end else if (st.fetch_pend && !wr_busy_in) begin
         n.dsp.req = 1'b1;
         n.dsp.addr = st.fetch_addr;
         n.dsp.len = st.fetch_first ? FIRST_FETCH_WORDS : REFILL_WORDS;
         n.dsp.be = BE_ALL;
         n.fetch_pend = 1'b0;
         n.fetch_first = 1'b0;
      end else if (st.tst == T_BURST && !st.fetch_pend &&
                   BUF_WORDS - st.cnt - st.inflight >= REFILL_WORDS) begin
         n.fetch_pend = 1'b1;
      end
      // Words that arrive after the burst ended are dropped
      if (dsp_rd_valid_in && st.inflight != 5'h00) begin
         n.inflight = n.inflight - 5'h01;
         push = st.rd_act;
      end
      if (push) begin
         n.buff[st.wptr] = dsp_rd_data_in;
         n.wptr = st.wptr + 4'h1;
      end
      if (pop) begin
         n.rptr = st.rptr + 4'h1;
      end
      n.cnt = st.cnt + {4'h0, push} - {4'h0, pop};
      if (flush) begin
         n.rd_act = 1'b0;
         n.fetch_pend = 1'b0;
         n.wptr = '0;
         n.rptr = '0;
         n.cnt = 5'h00;
      end

      // Master window translation
      n.mst.valid = mst_req_in.valid;
      if (mst_req_in.valid) begin
         if (mst_req_in.proxy) begin
            n.mst.addr = mst_req_in.addr;
            n.mst.cmd = mst_req_in.proxy_cmd;
         end else begin
            // Bits 31..28 were spent reaching the region and play no part here
            n.mst.addr = {st.sub[mst_req_in.addr[WIN_IDX_LSB +: WIN_IDX_W]],
                          mst_req_in.addr[WIN_IDX_LSB-1:0]};
            n.mst.cmd = pick_cmd(st.burst_en, mst_req_in.write, mst_req_in.len, st.cls);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st <= '0;
         st.tgt.devsel_n <= 1'b1;
         st.tgt.trdy_n <= 1'b1;
         st.tgt.stop_n <= 1'b1;
         st.s1.frame_n <= 1'b1;
         st.s1.irdy_n <= 1'b1;
         st.s2.frame_n <= 1'b1;
         st.s2.irdy_n <= 1'b1;
         st.tst <= T_IDLE;
      end else begin
         st <= n;
      end
   end

   assign reg_rdata_out = st.rdata;
   assign pci_tgt_out = st.tgt;
   assign dsp_rd_out = st.dsp;
   assign mst_out = st.mst;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_retry_shown;
      !pci_tgt_out.stop_n && !pci_tgt_out.devsel_n && pci_tgt_out.trdy_n;
   endsequence

   property p_retry_no_ready;
      !pci_tgt_out.stop_n |-> s_retry_shown;
   endproperty
   a_retry_no_ready: assert property (p_retry_no_ready) else $error("retry with ready");

   property p_fetch_after_writes;
      $rose(dsp_rd_out.req) |-> !$past(wr_busy_in);
   endproperty
   a_fetch_after_writes: assert property (p_fetch_after_writes) else $error("fetch early");

   property p_first_len;
      $rose(dsp_rd_out.req) && $past(st.fetch_first) |-> dsp_rd_out.len == 5'h10;
   endproperty
   a_first_len: assert property (p_first_len) else $error("first fetch length");

   property p_all_be;
      dsp_rd_out.req |-> dsp_rd_out.be == 4'hf;
   endproperty
   a_all_be: assert property (p_all_be) else $error("byte enables not all set");

   property p_wait_bound;
      st.tst == T_WAIT |-> st.wait_cnt < WAIT_PCLKS;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("wait exceeded");

   property p_force_no_wait;
      st.tst == T_WAIT && $past(st.tst) == T_IDLE |-> !$past(st.force_dly);
   endproperty
   a_force_no_wait: assert property (p_force_no_wait) else $error("waited while forced");

   property p_ready_with_select;
      $fell(pci_tgt_out.devsel_n) && st.tst == T_BURST |-> !pci_tgt_out.trdy_n;
   endproperty
   a_ready_with_select: assert property (p_ready_with_select) else $error("late ready");

   property p_refill_len;
      $rose(dsp_rd_out.req) && !$past(st.fetch_first) |-> dsp_rd_out.len == 5'h08;
   endproperty
   a_refill_len: assert property (p_refill_len) else $error("refill length");

   property p_sub_low_zero;
      reg_rd_in && reg_addr_in < 9'h080 |=> reg_rdata_out[22:0] == 23'h000000;
   endproperty
   a_sub_low_zero: assert property (p_sub_low_zero) else $error("reserved bits set");

   property p_translate;
      mst_req_in.valid && !mst_req_in.proxy |=>
         mst_out.addr == {$past(st.sub[mst_req_in.addr[27:23]]), $past(mst_req_in.addr[22:0])};
   endproperty
   a_translate: assert property (p_translate) else $error("window translation");
endmodule

// File: tb/prmw_dsp_slave_model.sv
// Behavioural DSP slave that answers the bridge prefetch reads
`timescale 1ns/100ps
module prmw_dsp_slave_model (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire prmw_pkg::prmw_dsp_rd_t rd_in,
   input wire logic [7:0] lat_in,
   output logic ack_out,
   output logic valid_out,
   output logic [31:0] data_out
);
   import prmw_pkg::*;
   logic [31:0] base;
   logic [4:0] n;
   // Each word carries its own address, so order and refill position show
   initial begin
      ack_out = 1'b0;
      valid_out = 1'b0;
      data_out = 32'h0;
      forever begin
         @(posedge sys_clk_in);
         if (!rst_in && rd_in.req === 1'b1) begin
            base = rd_in.addr;
            n = rd_in.len;
            ack_out <= 1'b1;
            @(posedge sys_clk_in);
            ack_out <= 1'b0;
            repeat (lat_in) @(posedge sys_clk_in);
            for (int i = 0; i < n; i++) begin
               valid_out <= 1'b1;
               data_out <= base + 32'(4 * i);
               @(posedge sys_clk_in);
            end
            valid_out <= 1'b0;
            // Inverted off-cycle data so a stray sample never matches
            data_out <= ~data_out;
         end
      end
   end
endmodule

// File: tb/prmw_bridge_tb.sv
// Self-checking bench for the read-multiple target path and master windows
`timescale 1ns/100ps
module prmw_bridge_tb;
   import prmw_pkg::*;
   localparam logic [31:0] A = 32'h8000_0000;
   logic sys_clk_in, rst_in, pci_clk, frame_n, irdy_n, reg_wr, reg_rd, wbuf_empty, wr_busy;
   logic ack, valid, both;
   logic [8:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, ad, rd_data;
   logic [3:0] cbe;
   logic [7:0] lat;
   prmw_tgt_out_t tgt;
   prmw_dsp_rd_t dsp_rd;
   prmw_mst_req_t mreq;
   prmw_mst_out_t mout;
   logic [31:0] fa[$];
   logic [4:0] fl[$];
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   int st, rises, ends;
   prmw_bridge #(.WAIT_PCLKS(4'h2)) prmw_bridge_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata), .pci_clk_in(pci_clk), .pci_frame_n_in(frame_n),
      .pci_irdy_n_in(irdy_n), .cmd_byte_enable_lines_in(cbe), .pci_ad_in(ad),
      .pci_tgt_out(tgt), .wbuf_empty_in(wbuf_empty), .wr_busy_in(wr_busy), .dsp_rd_out(dsp_rd),
      .dsp_rd_ack_in(ack), .dsp_rd_valid_in(valid), .dsp_rd_data_in(rd_data),
      .mst_req_in(mreq), .mst_out(mout));
   prmw_dsp_slave_model prmw_dsp_slave_model_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .rd_in(dsp_rd), .lat_in(lat), .ack_out(ack), .valid_out(valid), .data_out(rd_data));
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   // Bus clock runs free, offset so its edges never meet the system edges
   initial begin
      pci_clk = 1'b0;
      #7;
      forever #80 pci_clk = ~pci_clk;
   end
   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(posedge sys_clk_in) begin
      if (!rst_in && dsp_rd.req === 1'b1 && ack === 1'b1) begin
         fa.push_back(dsp_rd.addr);
         fl.push_back(dsp_rd.len);
         chk(dsp_rd.be, BE_ALL);
      end
   end
   task automatic reg_w(input logic [8:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_r(input logic [8:0] a, input logic [31:0] exp);
      @(posedge sys_clk_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic mst_chk(input logic wr, input logic px, input logic [31:0] a,
         input logic [4:0] len, input logic [3:0] ecmd, input logic [31:0] ea);
      @(posedge sys_clk_in);
      mreq <= '{valid: 1'b1, write: wr, proxy: px, proxy_cmd: 4'hb, addr: a, len: len};
      @(posedge sys_clk_in);
      mreq.valid <= 1'b0;
      #1;
      chk(mout.valid, 1'b1);
      chk(mout.cmd, ecmd);
      chk(mout.addr, ea);
   endtask
   task automatic slot();
      @(negedge pci_clk);
      @(posedge sys_clk_in);
   endtask
   // st: 0 no claim, 1 retry, 2 all n words read; rises: bus rise of first select
   task automatic pci_txn(input logic [31:0] a, input logic [3:0] cmd, input int n);
      int k;
      k = 0;
      st = 0;
      rises = 0;
      ends = 0;
      both = 1'b0;
      slot();
      frame_n <= 1'b0;
      cbe <= cmd;
      ad <= a;
      slot();
      cbe <= 4'h0;
      ad <= ~a;
      irdy_n <= 1'b0;
      frame_n <= (n == 1);
      for (int r = 1; r <= 24 && st == 0; r++) begin
         @(posedge pci_clk);
         #1;
         if (rises == 0 && tgt.devsel_n === 1'b0) begin
            rises = r;
            both = (tgt.trdy_n === 1'b0);
         end
         if (tgt.devsel_n === 1'b0) chk(tgt.ctl_oe, 1'b1);
         if (tgt.devsel_n === 1'b0 && tgt.stop_n === 1'b0) begin
            st = 1;
            ends = r;
         end else if (tgt.devsel_n === 1'b0 && tgt.trdy_n === 1'b0) begin
            chk(tgt.ad, (fa.size() > 0) ? fa[0] + 32'(4 * k) : 32'hx);
            chk(tgt.ad_oe, 1'b1);
            k++;
            if (k == n) st = 2;
         end
         slot();
         if (st != 0 || r == 24) begin
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
         end else if (k == n - 1) frame_n <= 1'b1;
      end
      repeat (3) @(posedge pci_clk);
      // Back on a system edge so later level changes land on it
      @(posedge sys_clk_in);
      chk({tgt.ctl_oe, tgt.ad_oe}, 2'b00);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      for (int w = 0; w < NUM_WIN; w++) reg_r(9'(4 * w), 32'h0);
      for (int w = 0; w < NUM_WIN; w++) reg_w(9'(4 * w), 32'h5a5a_5a5a ^ (32'(w) << 23));
      for (int w = 0; w < NUM_WIN; w++) reg_r(9'(4 * w), (32'h5a5a_5a5a ^ (32'(w) << 23)) & 32'hff80_0000);
      reg_r(9'h1fc, 32'h0);
   endtask
   task automatic t_windows();
      logic [31:0] d, a;
      reg_w(OFF_TGT_CTL, 32'h0);
      for (int w = 0; w < NUM_WIN; w++) begin
         d = 32'h5a5a_5a5a ^ (32'(w) << 23);
         a = {4'(w), 5'(w), 23'h2bcd ^ 23'(w)};
         mst_chk(w[0], 1'b0, a, 5'h10, w[0] ? CMD_MEM_WRITE : CMD_MEM_READ, {d[31:23], a[22:0]});
      end
      reg_w(OFF_TGT_CTL, 32'h0000_0802);
      mst_chk(1'b0, 1'b0, 32'h4000_0010, 5'h10, CMD_READ_MULTI, 32'h5a00_0010);
      mst_chk(1'b0, 1'b0, 32'h4000_0010, 5'h04, CMD_READ_LINE, 32'h5a00_0010);
      mst_chk(1'b0, 1'b0, 32'h4000_0010, 5'h01, CMD_MEM_READ, 32'h5a00_0010);
      mst_chk(1'b1, 1'b0, 32'h4000_0010, 5'h10, CMD_WRITE_INV, 32'h5a00_0010);
      mst_chk(1'b1, 1'b0, 32'h4000_0010, 5'h04, CMD_MEM_WRITE, 32'h5a00_0010);
      mst_chk(1'b0, 1'b1, 32'h1234_5678, 5'h01, 4'hb, 32'h1234_5678);
      reg_w(OFF_TGT_CTL, 32'h0);
   endtask
   task automatic t_decode();
      for (int i = 1; i < NUM_BAR; i++) reg_w(OFF_BAR + 9'(4 * i), 32'h1);
      reg_w(OFF_BAR_MSK, 32'hff00_0000);
      reg_w(OFF_BAR, 32'h8000_0001);
      pci_txn(A, CMD_READ_MULTI, 1);
      chk(st, 0);
      reg_w(OFF_BAR, A);
      pci_txn(A, CMD_READ_LINE, 1);
      chk(st, 0);
      pci_txn(32'h9000_0000, CMD_READ_MULTI, 1);
      chk(st, 0);
      reg_w(OFF_BAR_MSK, 32'hffff_ffff);
      fa.delete();
      pci_txn(A + 32'h8, CMD_READ_MULTI, 1);
      chk(st, 2);
      reg_w(OFF_BAR_MSK, 32'hff00_0000);
   endtask
   task automatic t_refill();
      fa.delete();
      fl.delete();
      pci_txn(A, CMD_READ_MULTI, 20);
      chk(st, 2);
      chk(fl[0], 5'h10);
      chk(fl[1], 5'h08);
      chk(fa[1], fa[0] + 32'h40);
   endtask
   task automatic t_busy();
      fa.delete();
      fl.delete();
      wr_busy <= 1'b1;
      pci_txn(A, CMD_READ_MULTI, 4);
      chk(st, 1);
      chk(fa.size(), 0);
      wr_busy <= 1'b0;
      repeat (12) @(posedge pci_clk);
      pci_txn(A, CMD_READ_MULTI, 4);
      chk(st, 2);
      chk(both, 1'b1);
      chk(fl[0], 5'h10);
   endtask
   task automatic t_delayed();
      fa.delete();
      lat <= 8'h3c;
      pci_txn(A, CMD_READ_MULTI, 2);
      chk(st, 1);
      // Two waiting bus rises, so the retry shows on the third
      chk(ends, 3);
      pci_txn(A + 32'h40, CMD_READ_MULTI, 1);
      chk(st, 1);
      repeat (16) @(posedge pci_clk);
      pci_txn(A, CMD_READ_MULTI, 2);
      chk(st, 2);
      chk(both, 1'b1);
      fa.delete();
      wbuf_empty <= 1'b0;
      pci_txn(A + 32'h80, CMD_READ_MULTI, 1);
      chk(st, 1);
      wbuf_empty <= 1'b1;
      reg_w(OFF_TGT_CTL, 32'h1);
      fa.delete();
      pci_txn(A + 32'hc0, CMD_READ_MULTI, 1);
      chk(st, 1);
      chk(ends, 1);
      reg_w(OFF_TGT_CTL, 32'h0);
      lat <= 8'h1;
      repeat (16) @(posedge pci_clk);
      pci_txn(A + 32'hc0, CMD_READ_MULTI, 1);
      chk(st, 2);
      chk(both, 1'b1);
   endtask
   initial begin
      rst_in = 1'b1;
      frame_n = 1'b1;
      irdy_n = 1'b1;
      cbe = 4'h0;
      ad = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 9'h0;
      reg_wdata = 32'h0;
      wbuf_empty = 1'b1;
      wr_busy = 1'b0;
      lat = 8'h1;
      mreq = '0;
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      t_regs();
      t_windows();
      t_decode();
      t_refill();
      t_busy();
      t_delayed();
      wrap_up();
   end
endmodule
